// ---- verilog/dps_map.svh ----
// Constants of the display power-down sequencer: offsets, fields, resets
// and timing. Assumes 8-bit registers on a plain index-addressed port.
// Function
// - Request low: bias enable high, DAC off
// - After retraces and refreshes: clocks, synth off
// - Panel tristate bit set, outputs go tristate
// - Supply bit 0 drives supply off high
// - Clearing tristate bit drives panel outputs low
// - Suspend refuses host access except three
// - Suspend refresh from one of four sources
// - Suspend tristates most outputs
// - Request rising restarts synthesizer and clocks
// - After refreshes and retraces panel resumes
// - Two frame pulses later bias enable low
// - Deep sleep loses register contents except divider and source
// - Deep sleep refresh from three sources
// - Reset falling wakes synthesizer, display idle
// - Default clocks about 100 ms later
// - Wake port write, then software restores
`ifndef DPS_MAP_SVH
`define DPS_MAP_SVH

`define DPS_IDX_PANEL_OUT   4'h0
`define DPS_IDX_POWER_MODE  4'h1
`define DPS_IDX_REF_TIMER   4'h2
`define DPS_IDX_PANEL_PWR   4'h3
`define DPS_IDX_REF_DIV     4'h4
`define DPS_IDX_REF_SRC     4'h5
`define DPS_IDX_STATUS      4'h6
`define DPS_IDX_WAKE_A      4'h7
`define DPS_IDX_WAKE_B      4'h8

`define DPS_BIT_TRISTATE    5
`define DPS_BIT_SUSPEND     7
`define DPS_BIT_INTERNAL    7
`define DPS_BIT_SUPPLY_ON   2

`define DPS_RST_PANEL_OUT   8'h00
`define DPS_RST_POWER_MODE  8'h00
`define DPS_RST_REF_TIMER   8'h00
`define DPS_RST_PANEL_PWR   8'h04
`define DPS_RST_REF_DIV     8'h00
`define DPS_RST_REF_SRC     8'h00

`define DPS_ENTRY_RETRACES  2
`define DPS_ENTRY_REFRESHES 2
`define DPS_EXIT_REFRESHES  2
`define DPS_EXIT_RETRACES   2
`define DPS_EXIT_FRAMES     2

`define DPS_CLK_KHZ         25000
`define DPS_SETTLE_MS       100

`endif

// ---- verilog/dps_pkg.sv ----
// Types shared by the display power-down sequencer.
// Assumes dps_map.svh supplies the numeric constants.
package dps_pkg;

    typedef enum logic [2:0] {
        ST_RUN,
        ST_ENTRY,
        ST_STOPPED,
        ST_DEEP,
        ST_IDLE,
        ST_RESUME,
        ST_FRAMES
    } dps_state_type;

    typedef enum logic [1:0] {
        SRC_REFRESH_IN,
        SRC_REF_DIVIDED,
        SRC_REF_PASS,
        SRC_LOCAL_PASS
    } dps_src_type;

    typedef struct packed {
        logic mem_clk_en;
        logic vid_clk_en;
        logic synth_en;
        logic slow_div8;
        logic defaults_ready;
    } dps_clk_ctrl_type;

endpackage

// ---- verilog/dps_sequencer.sv ----
// Display power-down sequencer: entry to and exit from suspend and deep
// sleep, clock gating, panel pin control and alternate refresh.
// Assumes retrace, refresh and frame strobes are one-cycle pulses made by
// the display timing logic, and all pins are sampled on MCLK.
`include "dps_map.svh"

module dps_sequencer
    import dps_pkg::*;
#(
    parameter int SETTLE_CYCLES = `DPS_SETTLE_MS * `DPS_CLK_KHZ
) (
    input  wire logic             MCLK,
    input  wire logic             RST_N,
    input  wire logic             POWER_DOWN_REQUEST_N,
    input  wire logic             POWER_RESET_IN,
    input  wire logic             HRETRACE_PULSE,
    input  wire logic             REFRESH_CYCLE_PULSE,
    input  wire logic             PANEL_FRAME_PULSE,
    input  wire logic             REFRESH_IN,
    input  wire logic             REFERENCE_CLOCK_IN,
    input  wire logic             LOCAL_REFRESH_CLOCK,
    input  wire logic [3:0]       REG_ADDR,
    input  wire logic [7:0]       REG_WDATA,
    input  wire logic             REG_WR,
    input  wire logic             REG_RD,
    output logic      [7:0]       REG_RDATA,
    output logic                  PANEL_BIAS_ENABLE_N,
    output logic                  PANEL_SUPPLY_OFF,
    output logic                  DAC_ENABLE,
    output dps_clk_ctrl_type      CLK_CTRL,
    output logic                  REFRESH_ALT_SEL,
    output logic                  CBR_REFRESH_OUT,
    output logic                  PANEL_OE,
    output logic                  PANEL_RUN,
    output logic                  OUTPUTS_OE,
    output logic                  HOST_MEM_ACCESS_EN
);

    dps_state_type    state_reg;
    dps_state_type    state_next;
    logic             req_meta_reg;
    logic             req_sync_reg;
    logic             req_last_reg;
    logic             rst_meta_reg;
    logic             rst_sync_reg;
    logic             rst_last_reg;
    logic [7:0]       panel_out_reg;
    logic [7:0]       power_mode_reg;
    logic [7:0]       ref_timer_reg;
    logic [7:0]       panel_pwr_reg;
    logic [7:0]       ref_div_reg;
    logic [7:0]       ref_src_reg;
    logic             awake_reg;
    logic [1:0]       ret_cnt_reg;
    logic [1:0]       rfs_cnt_reg;
    logic [1:0]       fp_cnt_reg;
    logic [21:0]      settle_cnt_reg;
    logic             settled_reg;
    logic [7:0]       div_cnt_reg;
    logic             div_out_reg;
    logic             refclk_last_reg;
    logic             cbr_reg;
    logic [7:0]       rdata_reg;
    logic             panel_run_reg;
    logic             bias_n_reg;
    dps_clk_ctrl_type clk_reg;

    localparam logic [21:0] SETTLE_LAST = 22'(SETTLE_CYCLES - 1);

    // Saturating pulse counter shared by the retrace, refresh and frame waits
    function automatic logic [1:0] count_up(input logic [1:0] c,
                                            input logic       p);
        count_up = (p && c != 2'h3) ? c + 2'h1 : c;
    endfunction

    function automatic logic reached(input logic [1:0] c,
                                     input int         n);
        reached = (c >= 2'(n));
    endfunction

    // Edges of synchronised pins only; first stage is never looked at
    wire req_fall = req_last_reg && !req_sync_reg;
    wire req_rise = !req_last_reg && req_sync_reg;
    wire rst_rise = !rst_last_reg && rst_sync_reg;
    wire rst_fall = rst_last_reg && !rst_sync_reg;

    // Software must have chosen suspend before ST_ENTRY can move on to ST_STOPPED
    wire suspend_sel = !ref_timer_reg[`DPS_BIT_INTERNAL]
                    && power_mode_reg[`DPS_BIT_SUSPEND];

    wire in_suspend = (state_reg == ST_STOPPED);
    wire in_deep    = (state_reg == ST_DEEP);
    wire in_idle    = (state_reg == ST_IDLE);
    // Before the wake write only the wake ports are honoured
    wire locked     = in_suspend || in_deep || (in_idle && !awake_reg);

    wire sel_pout  = (REG_ADDR == `DPS_IDX_PANEL_OUT);
    wire sel_pmode = (REG_ADDR == `DPS_IDX_POWER_MODE);
    wire sel_rtim  = (REG_ADDR == `DPS_IDX_REF_TIMER);
    wire sel_ppwr  = (REG_ADDR == `DPS_IDX_PANEL_PWR);
    wire sel_rdiv  = (REG_ADDR == `DPS_IDX_REF_DIV);
    wire sel_rsrc  = (REG_ADDR == `DPS_IDX_REF_SRC);
    wire sel_stat  = (REG_ADDR == `DPS_IDX_STATUS);
    wire sel_wake  = (REG_ADDR == `DPS_IDX_WAKE_A)
                  || (REG_ADDR == `DPS_IDX_WAKE_B);

    // In suspend only the tristate bit, supply and divider stay open
    wire susp_open = sel_pout || sel_ppwr || sel_rdiv;
    wire wr_ok     = REG_WR && (!locked || (in_suspend && susp_open)
                              || (in_deep && sel_rdiv));
    wire rd_ok     = REG_RD && (!locked || (in_suspend && susp_open));

    wire [7:0] pout_wmask = in_suspend ? 8'h20 : 8'hFF;

    wire wake_hit = REG_WR && in_idle && sel_wake;

    // Status word: state, awake, settled, panel running
    wire [7:0] status_word = {1'b0, panel_run_reg, settled_reg, awake_reg,
                              1'b0, state_reg};

    wire [7:0] rdata_next =
        !rd_ok    ? 8'h00 :
        sel_pout  ? panel_out_reg :
        sel_pmode ? power_mode_reg :
        sel_rtim  ? ref_timer_reg :
        sel_ppwr  ? panel_pwr_reg :
        sel_rdiv  ? ref_div_reg :
        sel_rsrc  ? ref_src_reg :
        sel_stat  ? status_word : 8'h00;

    // Refresh source: deep sleep has no local clock path, fall back
    wire [1:0]   src_raw = ref_src_reg[1:0];
    dps_src_type src_sel;
    assign src_sel = (in_deep && src_raw == 2'(SRC_LOCAL_PASS))
                   ? SRC_REFRESH_IN : dps_src_type'(src_raw);

    wire refclk_rise = REFERENCE_CLOCK_IN && !refclk_last_reg;
    wire div_wrap    = refclk_rise && (div_cnt_reg >= ref_div_reg);

    logic alt_refresh;
    always_comb begin
        case (src_sel)
            SRC_REFRESH_IN:  alt_refresh = REFRESH_IN;
            SRC_REF_DIVIDED: alt_refresh = div_out_reg;
            SRC_REF_PASS:    alt_refresh = REFERENCE_CLOCK_IN;
            SRC_LOCAL_PASS:  alt_refresh = LOCAL_REFRESH_CLOCK;
            default:         alt_refresh = REFRESH_IN;
        endcase
    end

    wire alt_active = (state_reg == ST_STOPPED) || in_deep;

    wire entry_done = reached(ret_cnt_reg, `DPS_ENTRY_RETRACES)
                   && reached(rfs_cnt_reg, `DPS_ENTRY_REFRESHES);
    wire resume_done = reached(ret_cnt_reg, `DPS_EXIT_RETRACES)
                    && reached(rfs_cnt_reg, `DPS_EXIT_REFRESHES);
    wire frames_done = reached(fp_cnt_reg, `DPS_EXIT_FRAMES);

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_RUN:
                if (req_fall) begin
                    state_next = ST_ENTRY;
                end
            ST_ENTRY:
                if (req_rise) begin
                    state_next = ST_RESUME;
                end else if (entry_done && suspend_sel) begin
                    state_next = ST_STOPPED;
                end
            ST_STOPPED:
                if (rst_rise) begin
                    state_next = ST_DEEP;
                end else if (req_rise) begin
                    state_next = ST_RESUME;
                end
            ST_DEEP:
                if (rst_fall) begin
                    state_next = ST_IDLE;
                end
            ST_IDLE:
                if (req_rise && awake_reg) begin
                    state_next = ST_RESUME;
                end
            ST_RESUME:
                if (req_fall) begin
                    state_next = ST_ENTRY;
                end else if (resume_done) begin
                    state_next = ST_FRAMES;
                end
            ST_FRAMES:
                if (req_fall) begin
                    state_next = ST_ENTRY;
                end else if (frames_done) begin
                    state_next = ST_RUN;
                end
            default:
                state_next = ST_RUN;
        endcase
    end

    wire clk_on = !(state_next == ST_STOPPED || state_next == ST_DEEP);

    dps_clk_ctrl_type clk_next;
    assign clk_next = '{
        mem_clk_en:     clk_on,
        vid_clk_en:     clk_on,
        synth_en:       clk_on,
        slow_div8:      (state_next == ST_IDLE),
        defaults_ready: settled_reg
    };

    wire dac_next  = (state_next == ST_RUN);
    wire bias_next = !(state_next == ST_RUN);
    wire run_next  = (state_next == ST_FRAMES) || (state_next == ST_RUN);
    wire restart   = (state_next != state_reg);

    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            req_meta_reg <= 1'b1;
            req_sync_reg <= 1'b1;
            req_last_reg <= 1'b1;
            rst_meta_reg <= 1'b0;
            rst_sync_reg <= 1'b0;
            rst_last_reg <= 1'b0;
        end else begin
            req_meta_reg <= POWER_DOWN_REQUEST_N;
            req_sync_reg <= req_meta_reg;
            req_last_reg <= req_sync_reg;
            rst_meta_reg <= POWER_RESET_IN;
            rst_sync_reg <= rst_meta_reg;
            rst_last_reg <= rst_sync_reg;
        end
    end

    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            state_reg   <= ST_RUN;
            ret_cnt_reg <= 2'h0;
            rfs_cnt_reg <= 2'h0;
            fp_cnt_reg  <= 2'h0;
        end else begin
            state_reg   <= state_next;
            ret_cnt_reg <= restart ? 2'h0
                         : count_up(ret_cnt_reg, HRETRACE_PULSE);
            rfs_cnt_reg <= restart ? 2'h0
                         : count_up(rfs_cnt_reg, REFRESH_CYCLE_PULSE);
            fp_cnt_reg  <= restart ? 2'h0
                         : count_up(fp_cnt_reg, PANEL_FRAME_PULSE);
        end
    end

    // Settling timer starts on the reset falling edge
    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            settle_cnt_reg <= 22'h000000;
            settled_reg    <= 1'b1;
        end else if (rst_fall) begin
            settle_cnt_reg <= 22'h000000;
            settled_reg    <= 1'b0;
        end else if (!settled_reg) begin
            settle_cnt_reg <= settle_cnt_reg + 22'h000001;
            settled_reg    <= (settle_cnt_reg >= SETTLE_LAST);
        end
    end

    // Deep sleep wipes display registers; refresh logic stays powered
    always_ff @(posedge MCLK) begin
        if (!RST_N || rst_rise) begin
            panel_out_reg  <= `DPS_RST_PANEL_OUT | {2'h0, RST_N, 5'h00};
            power_mode_reg <= `DPS_RST_POWER_MODE;
            ref_timer_reg  <= `DPS_RST_REF_TIMER;
            panel_pwr_reg  <= `DPS_RST_PANEL_PWR & ~{5'h00, RST_N, 2'h0};
            awake_reg      <= !RST_N;
        end else begin
            if (wake_hit) begin
                awake_reg <= 1'b1;
            end else if (state_reg == ST_RUN) begin
                awake_reg <= 1'b1;
            end
            if (wr_ok && sel_pout) begin
                panel_out_reg <= (panel_out_reg & ~pout_wmask)
                               | (REG_WDATA & pout_wmask);
            end
            if (wr_ok && sel_pmode) begin
                power_mode_reg <= REG_WDATA;
            end
            if (wr_ok && sel_rtim) begin
                ref_timer_reg <= REG_WDATA;
            end
            if (wr_ok && sel_ppwr) begin
                panel_pwr_reg <= REG_WDATA;
            end
        end
    end

    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            ref_div_reg <= `DPS_RST_REF_DIV;
            ref_src_reg <= `DPS_RST_REF_SRC;
        end else begin
            if (wr_ok && sel_rdiv) begin
                ref_div_reg <= REG_WDATA;
            end
            if (wr_ok && sel_rsrc) begin
                ref_src_reg <= REG_WDATA;
            end
        end
    end

    // Reference clock divided by the programmable divider
    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            refclk_last_reg <= 1'b0;
            div_cnt_reg     <= 8'h00;
            div_out_reg     <= 1'b0;
            cbr_reg         <= 1'b0;
        end else begin
            refclk_last_reg <= REFERENCE_CLOCK_IN;
            if (div_wrap) begin
                div_cnt_reg <= 8'h00;
                div_out_reg <= !div_out_reg;
            end else if (refclk_rise) begin
                div_cnt_reg <= div_cnt_reg + 8'h01;
            end
            cbr_reg <= alt_active ? alt_refresh : REFRESH_CYCLE_PULSE;
        end
    end

    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            clk_reg       <= '{1'b1, 1'b1, 1'b1, 1'b0, 1'b1};
            bias_n_reg    <= 1'b0;
            DAC_ENABLE    <= 1'b1;
            panel_run_reg <= 1'b1;
            rdata_reg     <= 8'h00;
        end else begin
            clk_reg       <= clk_next;
            bias_n_reg    <= bias_next;
            DAC_ENABLE    <= dac_next;
            panel_run_reg <= run_next;
            rdata_reg     <= rdata_next;
        end
    end

    // Panel pins: tristate bit wins, then forced low until resumed
    wire tristate = panel_out_reg[`DPS_BIT_TRISTATE];

    assign PANEL_OE            = !tristate;
    assign PANEL_RUN           = panel_run_reg && !tristate;
    assign PANEL_SUPPLY_OFF    = !panel_pwr_reg[`DPS_BIT_SUPPLY_ON];
    assign PANEL_BIAS_ENABLE_N = bias_n_reg;
    assign CLK_CTRL            = clk_reg;
    assign REFRESH_ALT_SEL     = alt_active;
    assign CBR_REFRESH_OUT     = cbr_reg;
    assign OUTPUTS_OE          = !(in_suspend || in_deep);
    assign HOST_MEM_ACCESS_EN  = (state_reg == ST_RUN);
    assign REG_RDATA           = rdata_reg;

endmodule

// ---- bench/dps_checker.sv ----
// Port checker for the display power-down sequencer.
// Assumes it is bound to every dps_sequencer instance below.
module dps_checker
    import dps_pkg::*;
(
    input wire logic             MCLK,
    input wire logic             RST_N,
    input wire logic             POWER_DOWN_REQUEST_N,
    input wire logic             POWER_RESET_IN,
    input wire logic             PANEL_FRAME_PULSE,
    input wire logic [3:0]       REG_ADDR,
    input wire logic [7:0]       REG_WDATA,
    input wire logic             REG_WR,
    input wire logic             REG_RD,
    input wire logic [7:0]       REG_RDATA,
    input wire logic             PANEL_BIAS_ENABLE_N,
    input wire logic             PANEL_SUPPLY_OFF,
    input wire logic             DAC_ENABLE,
    input wire dps_clk_ctrl_type CLK_CTRL,
    input wire logic             REFRESH_ALT_SEL,
    input wire logic             PANEL_OE,
    input wire logic             PANEL_RUN,
    input wire logic             OUTPUTS_OE,
    input wire logic             HOST_MEM_ACCESS_EN
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge MCLK); endclocking
    default disable iff (!RST_N);
    logic [1:0] frames_reg;
    // Frame strobes seen while the panel runs but bias is still off
    always_ff @(posedge MCLK) begin
        if (!RST_N || !PANEL_RUN || !PANEL_BIAS_ENABLE_N) begin
            frames_reg <= 2'h0;
        end else if (PANEL_FRAME_PULSE && frames_reg != 2'h3) begin
            frames_reg <= frames_reg + 2'h1;
        end
    end
    property p_supply;
        REG_WR && REG_ADDR == 4'h3 && HOST_MEM_ACCESS_EN
            |=> PANEL_SUPPLY_OFF == !$past(REG_WDATA[2]);
    endproperty
    a_supply: assert property (p_supply) else $error("supply pin wrong");
    property p_entry;
        $fell(HOST_MEM_ACCESS_EN)
            |-> ##[0:1] (PANEL_BIAS_ENABLE_N && !DAC_ENABLE);
    endproperty
    a_entry: assert property (p_entry) else $error("bias or DAC on");
    property p_stop;
        $fell(CLK_CTRL.mem_clk_en) |-> !CLK_CTRL.vid_clk_en
            && !CLK_CTRL.synth_en && REFRESH_ALT_SEL && !OUTPUTS_OE;
    endproperty
    a_stop: assert property (p_stop) else $error("stop incomplete");
    property p_tristate;
        REG_WR && REG_ADDR == 4'h0 && HOST_MEM_ACCESS_EN
            |=> PANEL_OE == !$past(REG_WDATA[5]);
    endproperty
    a_tristate: assert property (p_tristate) else $error("panel oe wrong");
    property p_drive_low;
        $rose(PANEL_OE) && !HOST_MEM_ACCESS_EN |-> !PANEL_RUN;
    endproperty
    a_drive_low: assert property (p_drive_low) else $error("not low");
    property p_wake;
        $rose(POWER_DOWN_REQUEST_N) && !CLK_CTRL.synth_en && !POWER_RESET_IN
            |-> ##[1:5] (CLK_CTRL.mem_clk_en && CLK_CTRL.synth_en);
    endproperty
    a_wake: assert property (p_wake) else $error("clocks stay off");
    property p_frames;
        $fell(PANEL_BIAS_ENABLE_N) && $past(RST_N) |-> frames_reg == 2'h2;
    endproperty
    a_frames: assert property (p_frames) else $error("bias early");
    property p_refuse;
        REG_RD && REG_ADDR == 4'h1 && !CLK_CTRL.synth_en
            |=> REG_RDATA == 8'h00;
    endproperty
    a_refuse: assert property (p_refuse) else $error("read served");
    property p_sync;
        $fell(HOST_MEM_ACCESS_EN) |-> !$past(POWER_DOWN_REQUEST_N, 3);
    endproperty
    a_sync: assert property (p_sync) else $error("request too fast");
endmodule

bind dps_sequencer dps_checker u_chk (
    .MCLK(MCLK), .RST_N(RST_N),
    .POWER_DOWN_REQUEST_N(POWER_DOWN_REQUEST_N),
    .POWER_RESET_IN(POWER_RESET_IN), .PANEL_FRAME_PULSE(PANEL_FRAME_PULSE),
    .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR),
    .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
    .PANEL_BIAS_ENABLE_N(PANEL_BIAS_ENABLE_N),
    .PANEL_SUPPLY_OFF(PANEL_SUPPLY_OFF), .DAC_ENABLE(DAC_ENABLE),
    .CLK_CTRL(CLK_CTRL), .REFRESH_ALT_SEL(REFRESH_ALT_SEL),
    .PANEL_OE(PANEL_OE), .PANEL_RUN(PANEL_RUN), .OUTPUTS_OE(OUTPUTS_OE),
    .HOST_MEM_ACCESS_EN(HOST_MEM_ACCESS_EN)
);

// ---- bench/dps_manager.sv ----
// Far side: power-down manager pins and display timing strobes.
// Assumes the bench paces sleep and deep sleep requests in time.
module dps_manager (
    input  wire logic MCLK,
    input  wire logic sleep_req,
    input  wire logic deep_req,
    input  wire logic slow,
    output logic      req_n,
    output logic      reset_pin,
    output logic      retrace,
    output logic      refresh,
    output logic      frame,
    output logic      ref_clk
);
    timeunit 1ns;
    timeprecision 1ns;
    // Wide enough never to wrap in a run, so strobe spacing stays even
    logic [15:0] cnt_reg = 16'h0000;
    // Slow mode spaces strobes three times wider
    always @(posedge MCLK) begin
        cnt_reg <= cnt_reg + 16'h0001;
        retrace <= cnt_reg % (slow ? 16'h0015 : 16'h0007) == 16'h0000;
        refresh <= cnt_reg % (slow ? 16'h000F : 16'h0005) == 16'h0000;
        frame <= cnt_reg % (slow ? 16'h0021 : 16'h000B) == 16'h0000;
        ref_clk <= cnt_reg[1];
        req_n <= !sleep_req;
        reset_pin <= deep_req;
    end
endmodule

// ---- bench/tb_top.sv ----
// Bench: register port, four suspend round trips, one deep sleep.
// Assumes dps_manager plays the manager; times scaled to MS cycles.
`include "dps_map.svh"

module tb_top
    import dps_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int MS = 25;
    logic             MCLK = 1'b0, RST_N = 1'b0, REG_WR = 1'b0, REG_RD = 1'b0;
    logic             REFRESH_IN = 1'b0, LOCAL_REFRESH_CLOCK = 1'b0;
    logic             sleep_req = 1'b0, deep_req = 1'b0, slow = 1'b0;
    logic [3:0]       REG_ADDR = 4'h0;
    logic [7:0]       REG_WDATA = 8'h00, rd_data, d;
    wire              req_n, reset_pin, retrace, refresh, frame, ref_clk;
    wire  [7:0]       REG_RDATA;
    wire              bias_n, supply_off, dac_en, alt_sel, cbr, panel_oe;
    wire              panel_run, outputs_oe, host_en;
    dps_clk_ctrl_type clk_ctrl;
    int               n_errors = 0, compares = 0, seed = 32'he071;
    int               n_ret = 0, n_rfr = 0, r0, f0;
    logic [7:0]       rst_tab [6] = '{`DPS_RST_PANEL_OUT, `DPS_RST_POWER_MODE,
        `DPS_RST_REF_TIMER, `DPS_RST_PANEL_PWR, `DPS_RST_REF_DIV,
        `DPS_RST_REF_SRC};
    // Index 0 DAC, 1 bias, 2 memory clock, 3 panel run, 4 ready, 5 host
    wire  [5:0]       obs = {host_en, clk_ctrl.defaults_ready, panel_run,
        clk_ctrl.mem_clk_en, bias_n, dac_en};
    dps_manager mgr (.MCLK(MCLK), .sleep_req(sleep_req), .deep_req(deep_req),
        .slow(slow), .req_n(req_n), .reset_pin(reset_pin), .retrace(retrace),
        .refresh(refresh), .frame(frame), .ref_clk(ref_clk));
    dps_sequencer #(.SETTLE_CYCLES(100 * MS)) dut (.MCLK(MCLK), .RST_N(RST_N),
        .POWER_DOWN_REQUEST_N(req_n), .POWER_RESET_IN(reset_pin),
        .HRETRACE_PULSE(retrace), .REFRESH_CYCLE_PULSE(refresh),
        .PANEL_FRAME_PULSE(frame), .REFRESH_IN(REFRESH_IN),
        .REFERENCE_CLOCK_IN(ref_clk), .LOCAL_REFRESH_CLOCK(LOCAL_REFRESH_CLOCK),
        .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR),
        .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .PANEL_BIAS_ENABLE_N(bias_n),
        .PANEL_SUPPLY_OFF(supply_off), .DAC_ENABLE(dac_en), .CLK_CTRL(clk_ctrl),
        .REFRESH_ALT_SEL(alt_sel), .CBR_REFRESH_OUT(cbr), .PANEL_OE(panel_oe),
        .PANEL_RUN(panel_run), .OUTPUTS_OE(outputs_oe),
        .HOST_MEM_ACCESS_EN(host_en));
    initial begin
        forever #20 MCLK = ~MCLK;
    end
    always @(posedge MCLK) begin
        REFRESH_IN <= 1'($random(seed));
        LOCAL_REFRESH_CLOCK <= 1'($random(seed));
        n_ret <= n_ret + int'(retrace);
        n_rfr <= n_rfr + int'(refresh);
    end
    function automatic logic pick(input int s);
        return s == 2 ? ref_clk : s == 3 ? LOCAL_REFRESH_CLOCK : REFRESH_IN;
    endfunction
    function automatic logic in_range(input int a, input int b);
        return a >= 2 && a <= 4 && b >= 2 && b <= 4;
    endfunction
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic finish_test;
        $display("compares %0d mismatches %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge MCLK);
        #1;
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        REG_WR <= 1'b1;
        REG_ADDR <= a;
        REG_WDATA <= v;
        @(posedge MCLK);
        REG_WR <= 1'b0;
        step(1);
    endtask
    task automatic rd(input logic [3:0] a);
        REG_RD <= 1'b1;
        REG_ADDR <= a;
        @(posedge MCLK);
        REG_RD <= 1'b0;
        #1;
        rd_data = REG_RDATA;
        step(1);
    endtask
    task automatic wait_on(input int i, input logic v);
        int k;
        k = 0;
        while (obs[i] !== v) begin
            step(1);
            k++;
            if (k > 3000) begin
                n_errors++;
                $display("timeout at %0t on signal %0d", $time, i);
                finish_test();
            end
        end
    endtask
    task automatic enter;
        sleep_req <= 1'b1;
        wait_on(0, 1'b0);
        chk(8'(bias_n), 8'h01);
        r0 = n_ret;
        f0 = n_rfr;
        wait_on(2, 1'b0);
        chk(8'(in_range(n_ret - r0, n_rfr - f0)), 8'h01);
        chk({5'h0, alt_sel, outputs_oe, host_en}, 8'h04);
        step(MS);
        wr(`DPS_IDX_PANEL_OUT, 8'h20);
        chk(8'(panel_oe), 8'h00);
        wr(`DPS_IDX_PANEL_PWR, 8'h00);
        chk(8'(supply_off), 8'h01);
    endtask
    task automatic leave;
        wr(`DPS_IDX_PANEL_PWR, 8'h04);
        chk(8'(supply_off), 8'h00);
        wr(`DPS_IDX_PANEL_OUT, 8'h00);
        chk({6'h0, panel_oe, panel_run}, 8'h02);
        step(100 * MS);
        sleep_req <= 1'b0;
        step(4);
        wait_on(2, 1'b1);
        r0 = n_ret;
        f0 = n_rfr;
        wait_on(3, 1'b1);
        chk(8'(in_range(n_ret - r0, n_rfr - f0)), 8'h01);
        wait_on(1, 1'b0);
        chk({6'h0, dac_en, host_en}, 8'h03);
    endtask
    task automatic follow(input int s);
        logic e;
        for (int k = 0; k < 12; k++) begin
            e = pick(s);
            step(1);
            chk(8'(cbr), 8'(e));
        end
    endtask
    initial begin
        int cnt;
        logic prev;
        step(8);
        RST_N <= 1'b1;
        step(1);
        chk({bias_n, supply_off, dac_en, panel_oe, panel_run, outputs_oe,
            host_en, 1'b0}, 8'h3E);
        chk({3'h0, clk_ctrl}, 8'h1D);
        for (int i = 0; i < 16; i++) begin
            rd(4'(i));
            chk(rd_data, i < 6 ? rst_tab[i] : i == 6 ? 8'h70 : 8'h00);
        end
        repeat (4) begin
            d = 8'($random(seed));
            wr(`DPS_IDX_REF_DIV, d);
            rd(`DPS_IDX_REF_DIV);
            chk(rd_data, d);
        end
        wr(`DPS_IDX_STATUS, 8'hFF);
        rd(`DPS_IDX_STATUS);
        chk(rd_data & 8'h07, 8'h00);
        wr(`DPS_IDX_PANEL_PWR, 8'h00);
        chk(8'(supply_off), 8'h01);
        wr(`DPS_IDX_PANEL_PWR, 8'h04);
        wr(`DPS_IDX_PANEL_OUT, 8'h20);
        chk(8'(panel_oe), 8'h00);
        wr(`DPS_IDX_PANEL_OUT, 8'h00);
        $display("test registers done");
        for (int s = 0; s < 4; s++) begin
            wr(`DPS_IDX_REF_SRC, 8'(s));
            wr(`DPS_IDX_REF_TIMER, 8'h00);
            wr(`DPS_IDX_POWER_MODE, 8'h80);
            enter();
            if (s == 1) begin
                wr(`DPS_IDX_REF_DIV, 8'h01);
                cnt = 0;
                prev = cbr;
                for (int k = 0; k < 64; k++) begin
                    step(1);
                    cnt += int'(cbr !== prev);
                    prev = cbr;
                end
                chk(8'(cnt >= 7 && cnt <= 9), 8'h01);
            end else begin
                follow(s);
            end
            rd(`DPS_IDX_POWER_MODE);
            chk(rd_data, 8'h00);
            rd(`DPS_IDX_PANEL_OUT);
            chk(rd_data, 8'h20);
            leave();
            $display("test suspend source %0d done", s);
        end
        slow <= 1'b1;
        wr(`DPS_IDX_REF_SRC, 8'h02);
        enter();
        step(300 * MS);
        deep_req <= 1'b1;
        step(6);
        wr(`DPS_IDX_REF_DIV, 8'h03);
        follow(2);
        step(300 * MS);
        deep_req <= 1'b0;
        step(6);
        chk({5'h0, clk_ctrl.synth_en, clk_ctrl.slow_div8,
            clk_ctrl.defaults_ready}, 8'h06);
        wait_on(4, 1'b1);
        wr(`DPS_IDX_PANEL_PWR, 8'h04);
        chk(8'(supply_off), 8'h01);
        wr(`DPS_IDX_WAKE_A, 8'h00);
        rd(`DPS_IDX_POWER_MODE);
        chk(rd_data, 8'h00);
        rd(`DPS_IDX_REF_DIV);
        chk(rd_data, 8'h03);
        leave();
        $display("test deep sleep done");
        finish_test();
    end
endmodule
